/* spi_master_model.sv */
// Serial bus master model for the memory pins
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
  // Serial pins
  output var logic sclk,
  output var logic sdi,
  output var logic selN,
  output var logic pauseN,
  input wire logic sdo,
  input wire logic sdoEn
);
  // ****
  // Frame tasks
  // ****
  localparam realtime HALF = 80.0;
  logic cpol;
  initial begin
    cpol = 1'b0;
    sclk = 1'b0;
    sdi = 1'b0;
    selN = 1'b1;
    pauseN = 1'b1;
  end
  task automatic open_frame(input logic mode);
    cpol = mode;
    sclk = mode;
    #HALF selN = 1'b0;
    #HALF;
  endtask : open_frame
  task automatic shift(input logic [7:0] dout, output logic [7:0] din);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = dout[i];
      #HALF sclk = 1'b1;
      din[i] = sdoEn ? sdo : ~sdo;
      #HALF;
    end
    sclk = cpol;
    sdi = ~sdi;
    #HALF;
  endtask : shift
  task automatic hold_link(input logic on);
    #HALF;
    if (!selN && !sclk) begin
      pauseN = ~on;
    end
    #HALF;
  endtask : hold_link
  task automatic wiggle();
    repeat (3) begin
      sclk = 1'b1;
      sdi = ~sdi;
      #HALF sclk = 1'b0;
      #HALF;
    end
  endtask : wiggle
  task automatic close_frame();
    sclk = cpol;
    #HALF selN = 1'b1;
    sdi = ~sdi;
    #HALF;
  endtask : close_frame
endmodule : spi_master_model
`default_nettype wire

/* spi_pin_interface.sv */
// Pin level serial interface of a small serial memory
`timescale 1ns/10ps
`default_nettype none
module spi_pin_interface
  import spi_pin_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic sclk,
  input wire logic sdi,
  input wire logic selN,
  input wire logic pauseN,
  input wire logic wpN,
  output logic sdo,
  output logic sdoEn,
  // Byte side
  output logic [7:0] rxByte,
  output logic rxValid,
  input wire logic [7:0] txData,
  output logic txTake,
  // Write control
  input wire logic welSet,
  input wire logic welClr,
  input wire logic writeReq,
  input wire logic writeIsArray,
  output logic writeAccepted,
  output logic writeRefused,
  output logic writeInProgress,
  output logic writeEnableLatch,
  // Non-volatile bits and status
  input wire logic statusLockBit,
  input wire logic blockProtectHi,
  input wire logic blockProtectLo,
  output logic [7:0] statusByte,
  // Link state
  output logic selected,
  output logic paused,
  output logic standby
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] pinSync;
  logic selNS, pauseNS, sclkS, sdiS, wpNS;

  sync_2ff #(.WIDTH(SYNC_W), .INIT(SYNC_INIT)) pinSyncInst (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({selN, pauseN, sclk, sdi, wpN}),
    .syncOut(pinSync)
  );

  assign selNS = pinSync[SY_SEL];
  assign pauseNS = pinSync[SY_PAUSE];
  assign sclkS = pinSync[SY_SCLK];
  assign sdiS = pinSync[SY_SDI];
  assign wpNS = pinSync[SY_WP];

  // ****************************************
  // Link state and serial shifting
  // ****************************************
  linkState_t state_q, state_d;
  logic armed_q, armed_d;
  logic selNPrev_q, selNPrev_d;
  logic sclkPrev_q, sclkPrev_d;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [7:0] rxShift_q, rxShift_d;
  logic [7:0] rxByte_q, rxByte_d;
  logic rxValid_q, rxValid_d;
  logic [7:0] txShift_q, txShift_d;
  logic sdo_q, sdo_d;
  logic sdoEn_q, sdoEn_d;
  logic selected_q, selected_d, paused_q, paused_d;
  logic txTake_q, txTake_d;
  logic selFall, riseAct, fallAct;

  always_comb begin
    selFall = selNPrev_q & ~selNS;
    riseAct = (state_q == LINK_ACTIVE) & ~selNS & sclkS & ~sclkPrev_q;
    fallAct = (state_q == LINK_ACTIVE) & ~selNS & ~sclkS & sclkPrev_q;
    state_d = state_q;
    armed_d = armed_q | selNS;
    selNPrev_d = selNS;
    sclkPrev_d = sclkS;
    bitCnt_d = bitCnt_q;
    rxShift_d = rxShift_q;
    rxByte_d = rxByte_q;
    rxValid_d = 1'b0;
    txShift_d = txShift_q;
    sdo_d = sdo_q;
    txTake_d = 1'b0;
    case (state_q)
      LINK_OFF: begin
        if (selFall && armed_q) begin
          state_d = LINK_ACTIVE;
          bitCnt_d = 3'd0;
        end
      end
      LINK_ACTIVE: begin
        if (selNS) begin
          state_d = LINK_OFF;
        end else if (!pauseNS && !sclkS) begin
          state_d = LINK_PAUSED;
        end
      end
      LINK_PAUSED: begin
        if (selNS) begin
          state_d = LINK_OFF;
        end else if (pauseNS && !sclkS) begin
          state_d = LINK_ACTIVE;
        end
      end
      default: begin
        state_d = LINK_OFF;
      end
    endcase
    if (riseAct) begin
      rxShift_d = {rxShift_q[6:0], sdiS};
      bitCnt_d = bitCnt_q + 3'd1;
      if (bitCnt_q == 3'd7) begin
        rxByte_d = {rxShift_q[6:0], sdiS};
        rxValid_d = 1'b1;
      end
    end
    if (fallAct) begin
      if (bitCnt_q == 3'd0) begin
        sdo_d = txData[7];
        txShift_d = {txData[6:0], 1'b0};
        txTake_d = 1'b1;
      end else begin
        sdo_d = txShift_q[7];
        txShift_d = {txShift_q[6:0], 1'b0};
      end
    end
    sdoEn_d = (state_d == LINK_ACTIVE);
    selected_d = (state_d != LINK_OFF);
    paused_d = (state_d == LINK_PAUSED);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= LINK_OFF;
      armed_q <= 1'b0;
      selNPrev_q <= 1'b0;
      sclkPrev_q <= 1'b0;
      bitCnt_q <= 3'd0;
      rxShift_q <= BYTE_RESET;
      rxByte_q <= BYTE_RESET;
      rxValid_q <= 1'b0;
      txShift_q <= BYTE_RESET;
      sdo_q <= 1'b0;
      sdoEn_q <= 1'b0;
      selected_q <= 1'b0;
      paused_q <= 1'b0;
      txTake_q <= 1'b0;
    end else begin
      state_q <= state_d;
      armed_q <= armed_d;
      selNPrev_q <= selNPrev_d;
      sclkPrev_q <= sclkPrev_d;
      bitCnt_q <= bitCnt_d;
      rxShift_q <= rxShift_d;
      rxByte_q <= rxByte_d;
      rxValid_q <= rxValid_d;
      txShift_q <= txShift_d;
      sdo_q <= sdo_d;
      sdoEn_q <= sdoEn_d;
      selected_q <= selected_d;
      paused_q <= paused_d;
      txTake_q <= txTake_d;
    end
  end

  // ****************************************
  // Write latch, write cycle and status
  // ****************************************
  logic wel_q, wel_d;
  logic busy_q, busy_d;
  logic [WRITE_CNT_W-1:0] wrCnt_q, wrCnt_d;
  logic accepted_q, accepted_d;
  logic refused_q, refused_d;
  logic standby_q, standby_d;
  logic [7:0] status_q, status_d;
  logic grant;

  always_comb begin
    grant = writeReq & ~busy_q & wel_q & (wpNS | ~writeIsArray);
    accepted_d = grant;
    refused_d = writeReq & ~grant;
    wel_d = wel_q;
    if (welClr || grant) begin
      wel_d = 1'b0;
    end
    if (welSet) begin
      wel_d = 1'b1;
    end
    busy_d = busy_q;
    wrCnt_d = wrCnt_q;
    if (grant) begin
      busy_d = 1'b1;
      wrCnt_d = WRITE_CNT_W'(WRITE_CYCLES - 1);
    end else if (busy_q) begin
      if (wrCnt_q == '0) begin
        busy_d = 1'b0;
      end else begin
        wrCnt_d = wrCnt_q - 1'b1;
      end
    end
    standby_d = (state_d == LINK_OFF) & ~busy_d;
    status_d = STATUS_RESET;
    status_d[STAT_WIP] = busy_d;
    status_d[STAT_WEL] = wel_d;
    status_d[STAT_BPLO] = blockProtectLo;
    status_d[STAT_BPHI] = blockProtectHi;
    status_d[STAT_LOCK] = statusLockBit;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      wrCnt_q <= '0;
      accepted_q <= 1'b0;
      refused_q <= 1'b0;
      standby_q <= 1'b1;
      status_q <= STATUS_RESET;
    end else begin
      wel_q <= wel_d;
      busy_q <= busy_d;
      wrCnt_q <= wrCnt_d;
      accepted_q <= accepted_d;
      refused_q <= refused_d;
      standby_q <= standby_d;
      status_q <= status_d;
    end
  end

  assign sdo = sdo_q;
  assign sdoEn = sdoEn_q;
  assign rxByte = rxByte_q;
  assign rxValid = rxValid_q;
  assign txTake = txTake_q;
  assign writeAccepted = accepted_q;
  assign writeRefused = refused_q;
  assign writeInProgress = busy_q;
  assign writeEnableLatch = wel_q;
  assign statusByte = status_q;
  assign selected = selected_q;
  assign paused = paused_q;
  assign standby = standby_q;

  // ****************************************
  // Assertions
  // ****************************************
  logic firstCyc_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      firstCyc_q <= 1'b1;
    end else begin
      firstCyc_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seqGrant;
    writeReq && !busy_q && wel_q && (wpNS || !writeIsArray);
  endsequence
  sequence seqPauseIn;
    (state_q == LINK_ACTIVE) && !selNS && !pauseNS && !sclkS;
  endsequence

  a_sdo_fall_only: assert property ($changed(sdo) |-> $past(fallAct))
    else $error("serial output changed without a falling clock edge");
  a_rx_on_rise: assert property (rxValid |-> $past(riseAct) && $past(bitCnt_q) == 3'd7)
    else $error("byte completed without an eighth rising edge");
  a_deselect_release: assert property (selNS |=> !sdoEn)
    else $error("output driven while deselected");
  a_standby_idle: assert property (standby |-> !selected && !writeInProgress)
    else $error("standby while selected or busy");
  a_need_select_fall: assert property (!armed_q |=> !selected)
    else $error("selected before select was seen high");
  a_pause_quiet: assert property (paused |-> !sdoEn && !rxValid)
    else $error("output or input active during pause");
  a_protect_refuse: assert property (writeReq && writeIsArray && !wpNS |=> writeRefused)
    else $error("array write accepted while protected");
  a_reset_state: assert property (firstCyc_q |-> !writeEnableLatch && !writeInProgress && !selected)
    else $error("state not cleared by reset");
  a_pause_entry: assert property (seqPauseIn |=> paused)
    else $error("pause not entered with clock low");
  a_write_busy: assert property (seqGrant |=> (writeInProgress && !standby) [*2])
    else $error("accepted write did not start a busy interval");
endmodule : spi_pin_interface
`default_nettype wire

/* spi_pin_interface_bench.sv */
// Self-checking bench for the serial memory pin interface
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module spi_pin_interface_bench;
  import spi_pin_pkg::*;
  // ****
  // Signals and instances
  // ****
  localparam int WCYC = 8;
  logic clk, rst_n, sclk, sdi, selN, pauseN, wpN, sdo, sdoEn, rxValid, txTake;
  logic welSet, welClr, writeReq, writeIsArray, writeAccepted, writeRefused;
  logic writeInProgress, writeEnableLatch, lockBit, bpHi, bpLo;
  logic selected, paused, standby;
  logic [7:0] rxByte, txData, statusByte, got, nv;
  int errors, compares, n, rxCnt, takeCnt;
  spi_pin_interface #(.WRITE_CYCLES(WCYC)) uut (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .sdi(sdi), .selN(selN), .pauseN(pauseN),
    .wpN(wpN), .sdo(sdo), .sdoEn(sdoEn), .rxByte(rxByte), .rxValid(rxValid),
    .txData(txData), .txTake(txTake), .welSet(welSet), .welClr(welClr),
    .writeReq(writeReq), .writeIsArray(writeIsArray), .writeAccepted(writeAccepted),
    .writeRefused(writeRefused), .writeInProgress(writeInProgress),
    .writeEnableLatch(writeEnableLatch), .statusLockBit(lockBit),
    .blockProtectHi(bpHi), .blockProtectLo(bpLo), .statusByte(statusByte),
    .selected(selected), .paused(paused), .standby(standby)
  );
  spi_master_model master (
    .sclk(sclk), .sdi(sdi), .selN(selN), .pauseN(pauseN), .sdo(sdo), .sdoEn(sdoEn)
  );
  always #2 clk = ~clk;
  always @(negedge clk) begin
    if (rxValid === 1'b1) begin
      rxCnt++;
    end
    if (txTake === 1'b1) begin
      takeCnt++;
    end
  end
  // ****
  // Helpers
  // ****
  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : pulse
  // ****
  // Scenarios
  // ****
  task automatic sc_idle();
    `CHK("standby", 1'b1, standby)
    `CHK("selected", 1'b0, selected)
    `CHK("sdoEn", 1'b0, sdoEn)
    `CHK("wel", 1'b0, writeEnableLatch)
    `CHK("wip", 1'b0, writeInProgress)
    `CHK("status", nv, statusByte)
  endtask : sc_idle
  task automatic sc_mode0();
    int rx0, tk0;
    rx0 = rxCnt;
    tk0 = takeCnt;
    txData = 8'h3C;
    master.open_frame(1'b0);
    `CHK("active", 1'b1, selected)
    `CHK("awake", 1'b0, standby)
    master.shift(8'hA5, got);
    `CHK("rx 1", 8'hA5, rxByte)
    master.shift(8'h0F, got);
    `CHK("tx 1", 8'h3C, got)
    `CHK("rx 2", 8'h0F, rxByte)
    master.hold_link(1'b1);
    `CHK("paused", 1'b1, paused)
    `CHK("pause hiz", 1'b0, sdoEn)
    `CHK("pause sel", 1'b1, selected)
    master.wiggle();
    master.hold_link(1'b0);
    `CHK("resumed", 1'b0, paused)
    master.shift(8'hC3, got);
    `CHK("rx 3", 8'hC3, rxByte)
    `CHK("tx 2", 8'h3C, got)
    master.close_frame();
    `CHK("desel hiz", 1'b0, sdoEn)
    `CHK("desel", 1'b0, selected)
    `CHK("standby", 1'b1, standby)
    `CHK("rx pulses", rx0 + 3, rxCnt)
    `CHK("tx loads", tk0 + 3, takeCnt)
  endtask : sc_mode0
  task automatic sc_mode1();
    int rx0, tk0;
    rx0 = rxCnt;
    tk0 = takeCnt;
    txData = 8'h96;
    master.open_frame(1'b1);
    master.shift(8'h69, got);
    `CHK("tx m11", 8'h96, got)
    `CHK("rx m11", 8'h69, rxByte)
    `CHK("rx pulses m11", rx0 + 1, rxCnt)
    `CHK("tx loads m11", tk0 + 1, takeCnt)
    master.close_frame();
  endtask : sc_mode1
  task automatic sc_write();
    step(1);
    wpN = 1'b0;
    step(4);
    pulse(welSet);
    `CHK("wel set", 1'b1, writeEnableLatch)
    writeIsArray = 1'b1;
    pulse(writeReq);
    `CHK("wp refuse", 1'b1, writeRefused)
    pulse(welSet);
    writeIsArray = 1'b0;
    writeReq = 1'b1;
    step(1);
    `CHK("accept", 1'b1, writeAccepted)
    `CHK("wel clr", 1'b0, writeEnableLatch)
    `CHK("busy", 1'b0, standby)
    n = 0;
    while (writeInProgress === 1'b1 && n < 20) begin
      step(1);
      writeReq = 1'b0;
      n++;
      if (n == 1) `CHK("busy refuse", 1'b1, writeRefused)
    end
    `CHK("busy len", WCYC, n)
    step(1);
    `CHK("idle", 1'b1, standby)
    pulse(welSet);
    pulse(welClr);
    `CHK("wel off", 1'b0, writeEnableLatch)
    wpN = 1'b1;
  endtask : sc_write
  task automatic sc_reset();
    lockBit = 1'b0;
    bpHi = 1'b1;
    bpLo = 1'b0;
    nv = 8'h00;
    nv[STAT_BPHI] = 1'b1;
    step(1);
    pulse(welSet);
    `CHK("nv live", nv | (8'h01 << STAT_WEL), statusByte)
    master.open_frame(1'b0);
    step(1);
    rst_n = 1'b0;
    master.shift(8'hE7, got);
    `CHK("por wel", 1'b0, writeEnableLatch)
    `CHK("por rx", 8'h00, rxByte)
    step(1);
    rst_n = 1'b1;
    step(8);
    `CHK("no fall", 1'b0, selected)
    `CHK("por nv", nv, statusByte)
    master.close_frame();
    master.open_frame(1'b0);
    `CHK("armed", 1'b1, selected)
    master.close_frame();
  endtask : sc_reset
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    errors = 0;
    compares = 0;
    nv = 8'h00;
    nv[STAT_LOCK] = 1'b1;
    nv[STAT_BPLO] = 1'b1;
    lockBit = 1'b1;
    bpHi = 1'b0;
    bpLo = 1'b1;
    wpN = 1'b1;
    txData = 8'h00;
    welSet = 1'b0;
    welClr = 1'b0;
    writeReq = 1'b0;
    writeIsArray = 1'b0;
    step(4);
    rst_n = 1'b1;
    step(6);
    sc_idle();
    sc_mode0();
    sc_mode1();
    sc_write();
    sc_reset();
    close_out();
  end
  initial begin
    #40000;
    errors++;
    close_out();
  end
endmodule : spi_pin_interface_bench
`default_nettype wire

/* spi_pin_pkg.sv */
// Constants and types for the serial memory pin interface
// Function
// - The serial output bit changes only on a falling clock edge.
// - The serial input is sampled on each rising clock edge.
// - While select is high the device is deselected and its output is released.
// - Deselected without a write cycle running means standby; select low means active.
// - After reset a falling edge on select is needed before the device is selected.
// - While paused the output is released and clock and input are ignored.
// - While write protect is low, memory array writes are refused and all else works.
// - While the power-on reset is asserted every instruction is ignored.
// - After reset the device is deselected, in standby, waiting for a select fall.
// - Reset clears the write enable latch and the write in progress bit.
// - Reset leaves the lock bit and both block protect bits at their stored values.
// - All bytes travel most significant bit first, in both directions.
// - A pause starts or ends only while the clock is low; a pause pin change made with the clock high takes effect when the clock goes low.
`default_nettype none
package spi_pin_pkg;
  // ****************************************
  // Byte and status layout
  // ****************************************
  localparam int BYTE_BITS = 8;
  localparam int STAT_WIP = 0;
  localparam int STAT_WEL = 1;
  localparam int STAT_BPLO = 2;
  localparam int STAT_BPHI = 3;
  localparam int STAT_LOCK = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // ****************************************
  // Synchroniser lanes and reset values
  // ****************************************
  localparam int SYNC_W = 5;
  localparam int SY_SEL = 4;
  localparam int SY_PAUSE = 3;
  localparam int SY_SCLK = 2;
  localparam int SY_SDI = 1;
  localparam int SY_WP = 0;
  localparam logic [4:0] SYNC_INIT = 5'h08;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_MHZ = 250;
  localparam int WRITE_TIME_US = 5;
  localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_FREQ_MHZ;
  localparam int WRITE_CNT_W = 16;
  // ****************************************
  // Link states
  // ****************************************
  typedef enum logic [1:0] {
    LINK_OFF,
    LINK_ACTIVE,
    LINK_PAUSED
  } linkState_t;
endpackage : spi_pin_pkg
`default_nettype wire

/* sync_2ff.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = pinIn;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule : sync_2ff
`default_nettype wire
